// ---- design/olsub_defs.svh ----
// Offsets, reset values and source codes for the output line block.
// Assumes a plain register port with word addresses and 32-bit data.
`ifndef OLSUB_DEFS_SVH
`define OLSUB_DEFS_SVH

`define OLSUB_ADDR_W 8
`define OLSUB_OFF_PIN_INDEX 8'h00
`define OLSUB_OFF_PIN_DIR 8'h01
`define OLSUB_OFF_PIN_FLIP 8'h02
`define OLSUB_OFF_SOURCE 8'h03
`define OLSUB_OFF_FORMAT 8'h04
`define OLSUB_OFF_BIT_INDEX 8'h05
`define OLSUB_OFF_BIT_LEVEL 8'h06
`define OLSUB_OFF_WORD 8'h07
`define OLSUB_OFF_WRITE_EN 8'h08
`define OLSUB_OFF_PIN_STATE 8'h09

`define OLSUB_SRC_OFF 8'h00
`define OLSUB_SRC_CAP_WAIT 8'h01
`define OLSUB_SRC_CAP_RUN 8'h02
`define OLSUB_SRC_IMG_WAIT 8'h03
`define OLSUB_SRC_IMG_RUN 8'h04
`define OLSUB_SRC_INTEG 8'h05
`define OLSUB_SRC_PULSE_BASE 8'h10
`define OLSUB_SRC_TALLY_BASE 8'h20
`define OLSUB_SRC_SOFT_BASE 8'h40

`define OLSUB_FMT_RST 8'h01
`define OLSUB_WRITE_EN_RST 32'hffffffff

`endif

// ---- design/olsub_pkg.sv ----
// Types shared by the output line block.
// Assumes olsub_defs.svh for numeric constants.
package olsub_pkg;
    typedef struct packed {
        logic capture_awaiting_trigger;
        logic capture_in_progress;
        logic image_awaiting_trigger;
        logic image_in_progress;
        logic integration_in_progress;
    } olsub_acq_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } olsub_bus_t;
endpackage

// ---- design/olsub_lines.sv ----
// Output line source selection and soft output bits for a set of connector lines.
// Assumes a register master with one-cycle strobes and pins resolved by the bench.
// How it works
// RULE1 - A line outputs its chosen source only while set to output direction.
// RULE2 - Source off disables the driver, leaving the pin tri-stated.
// RULE3 - Capture-awaiting-trigger and capture-in-progress are selectable sources.
// RULE4 - Image-awaiting-trigger and image-in-progress are selectable sources.
// RULE5 - Integration-in-progress is a selectable source.
// RULE6 - Each pulse generator's running state is a selectable source.
// RULE7 - Each tally's counting state is a selectable source.
// RULE8 - A soft bit source drives the stored value of that bit.
// RULE9 - Soft bit index n addresses bit n, counting from zero.
// RULE10 - Writing the bit level sets or clears only the indexed bit.
// RULE11 - Whole word write sets soft bits, bit 0 to soft bit zero.
// RULE12 - Whole word write changes only bits whose write enable is one.
// RULE13 - The single bit path ignores the whole word write enable.
// RULE14 - Two-way lines come up as inputs.
// RULE15 - Polarity flip is applied after source selection.
// RULE16 - Sources reset to off and soft bits reset to low.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "olsub_defs.svh"

module olsub_lines
    import olsub_pkg::*;
#(
    parameter int LINES = 4,
    parameter int SOFT_BITS = 8,
    parameter int PULSE_GENS = 2,
    parameter int TALLIES = 2
) (
    input wire logic core_clk_in, // 40 MHz clock
    input wire logic sys_rst_in, // synchronous reset, active high
    input wire olsub_bus_t bus_in, // register request
    output logic [31:0] rdata_out, // read data, cycle after read strobe
    input wire olsub_acq_t acq_in, // acquisition status levels
    input wire logic [PULSE_GENS-1:0] pulse_gen_running_in, // pulse generators active
    input wire logic [TALLIES-1:0] tally_running_in, // tallies counting
    input wire logic [LINES-1:0] pin_in, // pin levels as seen
    output logic [LINES-1:0] pin_out, // pin drive levels
    output logic [LINES-1:0] pin_oe_out // pin drive enables
);
    logic [7:0] pin_index_ff;
    logic [LINES-1:0] pin_direction_ff;
    logic [LINES-1:0] pin_polarity_flip_ff;
    logic [7:0] source_ff [LINES];
    logic [7:0] format_ff [LINES];
    logic [7:0] soft_bit_index_ff;
    logic [SOFT_BITS-1:0] soft_bits_ff;
    logic [SOFT_BITS-1:0] write_enable_ff;
    logic [31:0] rdata_ff;
    logic [LINES-1:0] pin_level_ff;
    logic [LINES-1:0] pin_oe_ff;
    logic sel_ok;
    logic [LINES-1:0] sel_dec;

    assign sel_ok = pin_index_ff < 8'(LINES);

    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            sel_dec[i] = sel_ok && (pin_index_ff == 8'(i));
        end
    end

    // Picks one internal level; unknown codes give low so a bad setting stays quiet.
    function automatic logic pick_source(input logic [7:0] code,
                                         input olsub_acq_t acq,
                                         input logic [PULSE_GENS-1:0] pg,
                                         input logic [TALLIES-1:0] ty,
                                         input logic [SOFT_BITS-1:0] sb);
        logic v;
        v = 1'b0;
        case (code)
            `OLSUB_SRC_CAP_WAIT: v = acq.capture_awaiting_trigger; // RULE3
            `OLSUB_SRC_CAP_RUN: v = acq.capture_in_progress; // RULE3
            `OLSUB_SRC_IMG_WAIT: v = acq.image_awaiting_trigger; // RULE4
            `OLSUB_SRC_IMG_RUN: v = acq.image_in_progress; // RULE4
            `OLSUB_SRC_INTEG: v = acq.integration_in_progress; // RULE5
            default: begin
                for (int k = 0; k < PULSE_GENS; k++) begin
                    if (code == `OLSUB_SRC_PULSE_BASE + 8'(k)) v = pg[k]; // RULE6
                end
                for (int k = 0; k < TALLIES; k++) begin
                    if (code == `OLSUB_SRC_TALLY_BASE + 8'(k)) v = ty[k]; // RULE7
                end
                for (int k = 0; k < SOFT_BITS; k++) begin
                    if (code == `OLSUB_SRC_SOFT_BASE + 8'(k)) v = sb[k]; // RULE8
                end
            end
        endcase
        return v;
    endfunction

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pin_index_ff <= 8'h00;
        end else if (bus_in.wr && bus_in.addr == `OLSUB_OFF_PIN_INDEX) begin
            pin_index_ff <= bus_in.wdata[7:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pin_direction_ff <= '0; // RULE14
            pin_polarity_flip_ff <= '0;
        end else if (bus_in.wr) begin
            for (int i = 0; i < LINES; i++) begin
                if (sel_dec[i] && bus_in.addr == `OLSUB_OFF_PIN_DIR) begin
                    pin_direction_ff[i] <= bus_in.wdata[0];
                end
                if (sel_dec[i] && bus_in.addr == `OLSUB_OFF_PIN_FLIP) begin
                    pin_polarity_flip_ff[i] <= bus_in.wdata[0];
                end
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < LINES; i++) begin
                source_ff[i] <= `OLSUB_SRC_OFF; // RULE16
                format_ff[i] <= `OLSUB_FMT_RST;
            end
        end else if (bus_in.wr) begin
            for (int i = 0; i < LINES; i++) begin
                if (sel_dec[i] && bus_in.addr == `OLSUB_OFF_SOURCE) begin
                    source_ff[i] <= bus_in.wdata[7:0];
                end
                if (sel_dec[i] && bus_in.addr == `OLSUB_OFF_FORMAT) begin
                    format_ff[i] <= bus_in.wdata[7:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            soft_bit_index_ff <= 8'h00;
            write_enable_ff <= SOFT_BITS'(`OLSUB_WRITE_EN_RST);
        end else if (bus_in.wr) begin
            if (bus_in.addr == `OLSUB_OFF_BIT_INDEX) begin
                soft_bit_index_ff <= bus_in.wdata[7:0];
            end
            if (bus_in.addr == `OLSUB_OFF_WRITE_EN) begin
                write_enable_ff <= bus_in.wdata[SOFT_BITS-1:0];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            soft_bits_ff <= '0; // RULE16
        end else if (bus_in.wr && bus_in.addr == `OLSUB_OFF_BIT_LEVEL) begin
            for (int k = 0; k < SOFT_BITS; k++) begin
                if (soft_bit_index_ff == 8'(k)) begin // RULE9
                    soft_bits_ff[k] <= bus_in.wdata[0]; // RULE10 RULE13
                end
            end
        end else if (bus_in.wr && bus_in.addr == `OLSUB_OFF_WORD) begin
            soft_bits_ff <= (soft_bits_ff & ~write_enable_ff)
                | (bus_in.wdata[SOFT_BITS-1:0] & write_enable_ff); // RULE11 RULE12
        end
    end

    // Drive path is registered so pins never glitch while a source code changes.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pin_level_ff <= '0;
            pin_oe_ff <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                pin_oe_ff[i] <= pin_direction_ff[i]
                    && source_ff[i] != `OLSUB_SRC_OFF; // RULE1 RULE2
                pin_level_ff[i] <= pin_polarity_flip_ff[i]
                    ^ pick_source(source_ff[i], acq_in, pulse_gen_running_in,
                                  tally_running_in, soft_bits_ff); // RULE15
            end
        end
    end

    assign pin_out = pin_level_ff;
    assign pin_oe_out = pin_oe_ff;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 32'h00000000;
        end else if (bus_in.rd) begin
            rdata_ff <= 32'h00000000;
            case (bus_in.addr)
                `OLSUB_OFF_PIN_INDEX: rdata_ff[7:0] <= pin_index_ff;
                `OLSUB_OFF_BIT_INDEX: rdata_ff[7:0] <= soft_bit_index_ff;
                `OLSUB_OFF_WORD: rdata_ff[SOFT_BITS-1:0] <= soft_bits_ff;
                `OLSUB_OFF_WRITE_EN: rdata_ff[SOFT_BITS-1:0] <= write_enable_ff;
                `OLSUB_OFF_BIT_LEVEL: begin
                    for (int k = 0; k < SOFT_BITS; k++) begin
                        if (soft_bit_index_ff == 8'(k)) rdata_ff[0] <= soft_bits_ff[k];
                    end
                end
                `OLSUB_OFF_PIN_STATE: rdata_ff[LINES-1:0] <= pin_in ^ pin_polarity_flip_ff;
                default: begin
                    for (int i = 0; i < LINES; i++) begin
                        if (sel_dec[i]) begin
                            case (bus_in.addr)
                                `OLSUB_OFF_PIN_DIR: rdata_ff[0] <= pin_direction_ff[i];
                                `OLSUB_OFF_PIN_FLIP: rdata_ff[0] <= pin_polarity_flip_ff[i];
                                `OLSUB_OFF_SOURCE: rdata_ff[7:0] <= source_ff[i];
                                `OLSUB_OFF_FORMAT: rdata_ff[7:0] <= format_ff[i];
                                default: rdata_ff[7:0] <= 8'h00;
                            endcase
                        end
                    end
                end
            endcase
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign rdata_out = rdata_ff;

    property p_off_tristate;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_OFF) |=> !pin_oe_out[0];
    endproperty
    a_off_tristate: assert property (p_off_tristate) else $error("line 0 driven while off"); // RULE2

    property p_input_no_drive;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !pin_direction_ff[0] |=> !pin_oe_out[0];
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) else $error("input line driven"); // RULE1

    property p_integ_route;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_INTEG && !pin_polarity_flip_ff[0])
            |=> pin_out[0] == $past(acq_in.integration_in_progress);
    endproperty
    a_integ_route: assert property (p_integ_route) else $error("integration not routed"); // RULE5

    property p_flip;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_CAP_RUN && pin_polarity_flip_ff[0])
            |=> pin_out[0] == !$past(acq_in.capture_in_progress);
    endproperty
    a_flip: assert property (p_flip) else $error("flip not applied"); // RULE15

    property p_soft_route;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_SOFT_BASE && !pin_polarity_flip_ff[0])
            |=> pin_out[0] == $past(soft_bits_ff[0]);
    endproperty
    a_soft_route: assert property (p_soft_route) else $error("soft bit not routed"); // RULE8

    property p_bit_write;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_BIT_LEVEL && soft_bit_index_ff == 8'h00)
            |=> soft_bits_ff[0] == $past(bus_in.wdata[0]);
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write lost"); // RULE10

    property p_bit_others;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_BIT_LEVEL && soft_bit_index_ff != 8'h00)
            |=> soft_bits_ff[0] == $past(soft_bits_ff[0]);
    endproperty
    a_bit_others: assert property (p_bit_others) else $error("other bit disturbed"); // RULE10

    property p_mask;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_WORD && !write_enable_ff[0])
            |=> $stable(soft_bits_ff[0]);
    endproperty
    a_mask: assert property (p_mask) else $error("masked bit changed"); // RULE12

    property p_word;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_WORD && write_enable_ff[0])
            |=> soft_bits_ff[0] == $past(bus_in.wdata[0]);
    endproperty
    a_word: assert property (p_word) else $error("word write lost"); // RULE11

    // Line 0 stands for every line here, since one loop builds the drive path of all lines.
    property p_drive_on;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (pin_direction_ff[0] && source_ff[0] != `OLSUB_SRC_OFF) |=> pin_oe_out[0];
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("output line not driven"); // RULE1

    property p_cap_wait;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_CAP_WAIT && !pin_polarity_flip_ff[0])
            |=> pin_out[0] == $past(acq_in.capture_awaiting_trigger);
    endproperty
    a_cap_wait: assert property (p_cap_wait) else $error("capture wait lost"); // RULE3

    property p_img_run;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_IMG_RUN && !pin_polarity_flip_ff[0])
            |=> pin_out[0] == $past(acq_in.image_in_progress);
    endproperty
    a_img_run: assert property (p_img_run) else $error("image run lost"); // RULE4

    property p_pulse0;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_PULSE_BASE && !pin_polarity_flip_ff[0])
            |=> pin_out[0] == $past(pulse_gen_running_in[0]);
    endproperty
    a_pulse0: assert property (p_pulse0) else $error("pulse generator lost"); // RULE6

    property p_tally0;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (source_ff[0] == `OLSUB_SRC_TALLY_BASE && !pin_polarity_flip_ff[0])
            |=> pin_out[0] == $past(tally_running_in[0]);
    endproperty
    a_tally0: assert property (p_tally0) else $error("tally state lost"); // RULE7

    property p_idx_range;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_BIT_LEVEL
            && soft_bit_index_ff >= 8'(SOFT_BITS)) |=> $stable(soft_bits_ff);
    endproperty
    a_idx_range: assert property (p_idx_range) else $error("bad index wrote a bit"); // RULE9

    property p_mask_all;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_WORD)
            |=> ((soft_bits_ff ^ $past(soft_bits_ff)) & ~$past(write_enable_ff)) == '0;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("disabled bit changed"); // RULE12

    property p_bit_one;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        (bus_in.wr && bus_in.addr == `OLSUB_OFF_BIT_LEVEL)
            |=> $countones(soft_bits_ff ^ $past(soft_bits_ff)) <= 1;
    endproperty
    a_bit_one: assert property (p_bit_one) else $error("bit write hit many bits"); // RULE10

    property p_rst_quiet;
        @(posedge core_clk_in)
        sys_rst_in |=> (pin_oe_out == '0 && soft_bits_ff == '0
            && source_ff[0] == `OLSUB_SRC_OFF);
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset state wrong"); // RULE16

    property p_rst_input;
        @(posedge core_clk_in)
        sys_rst_in |=> pin_direction_ff == '0;
    endproperty
    a_rst_input: assert property (p_rst_input) else $error("line not input after reset"); // RULE14
endmodule

// ---- testbench/olsub_ext_equip.sv ----
// External equipment on the connector lines: a pull-up per line and a passive receiver.
// Assumes the block's per-line drive level and drive enable, high enable meaning driven.
`timescale 1ns/1ps

module olsub_ext_equip #(
    parameter int LINES = 4
) (
    input wire logic [LINES-1:0] drive_in, // drive level from the block
    input wire logic [LINES-1:0] drive_en_in, // drive enable from the block
    output logic [LINES-1:0] wire_level_out // resolved level on each connector line
);
    // An undriven line floats up to its pull-up, so a stale level is never seen.
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            wire_level_out[i] = drive_en_in[i] ? drive_in[i] : 1'b1;
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the output line block: register tasks and pin comparisons.
// Assumes the register offsets and source codes of olsub_defs.svh and default sizes.
`timescale 1ns/1ps
`include "olsub_defs.svh"

module tb_top
    import olsub_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    olsub_bus_t bus = '0;
    logic [31:0] rdata;
    logic [8:0] stat = '0;
    logic [3:0] pin_lvl;
    logic [3:0] pin_drv;
    logic [3:0] pin_oe;
    int fail_count = 0;
    int check_count = 0;
    localparam logic [7:0] CODES [9] = '{`OLSUB_SRC_CAP_WAIT, `OLSUB_SRC_CAP_RUN,
        `OLSUB_SRC_IMG_WAIT, `OLSUB_SRC_IMG_RUN, `OLSUB_SRC_INTEG, 8'h10, 8'h11, 8'h20, 8'h21};
    localparam int POS [9] = '{8, 7, 6, 5, 4, 2, 3, 0, 1};

    always #12.5 core_clk_in = ~core_clk_in;

    olsub_lines i_olsub_lines (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .bus_in(bus),
        .rdata_out(rdata),
        .acq_in(stat[8:4]),
        .pulse_gen_running_in(stat[3:2]),
        .tally_running_in(stat[1:0]),
        .pin_in(pin_lvl),
        .pin_out(pin_drv),
        .pin_oe_out(pin_oe)
    );

    olsub_ext_equip i_olsub_ext_equip (
        .drive_in(pin_drv),
        .drive_en_in(pin_oe),
        .wire_level_out(pin_lvl)
    );

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // The level is only compared while the line is expected to be driven.
    task automatic chk_pin(input int l, input logic eoe, input logic ev, input string m);
        check_count++;
        if (pin_oe[l] !== eoe || (eoe && pin_drv[l] !== ev)) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s line %0d oe %b lvl %b", $time, m, l,
                pin_oe[l], pin_drv[l]);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in) bus <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk_in) bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        @(posedge core_clk_in) bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge core_clk_in) bus <= '0;
        #1 chk32(rdata, e, m);
    endtask

    task automatic settle;
        repeat (2) @(posedge core_clk_in);
        #1;
    endtask

    initial begin
        #(25 * 3000);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        #1;
        for (int l = 0; l < 4; l++) chk_pin(l, 1'b0, 1'b0, "reset drive");
        rd(`OLSUB_OFF_SOURCE, 32'h0, "reset source");
        rd(`OLSUB_OFF_WORD, 32'h0, "reset soft bits");
        rd(`OLSUB_OFF_WRITE_EN, 32'h0000_00ff, "reset write enable");
        rd(`OLSUB_OFF_FORMAT, 32'h0000_0001, "reset format");
        $display("test reset done");

        wr(`OLSUB_OFF_PIN_DIR, 32'h1);
        for (int i = 0; i < 9; i++) begin
            wr(`OLSUB_OFF_SOURCE, {24'h0, CODES[i]});
            @(posedge core_clk_in) stat <= 9'h1 << POS[i];
            settle();
            chk_pin(0, 1'b1, 1'b1, "source high");
            @(posedge core_clk_in) stat <= ~(9'h1 << POS[i]);
            settle();
            chk_pin(0, 1'b1, 1'b0, "source low");
        end
        rd(`OLSUB_OFF_SOURCE, 32'h21, "source readback");
        $display("test sources done");

        wr(`OLSUB_OFF_SOURCE, {24'h0, `OLSUB_SRC_CAP_RUN});
        @(posedge core_clk_in) stat <= 9'h080;
        wr(`OLSUB_OFF_PIN_FLIP, 32'h1);
        settle();
        chk_pin(0, 1'b1, 1'b0, "flipped source");
        wr(`OLSUB_OFF_PIN_DIR, 32'h0);
        settle();
        chk_pin(0, 1'b0, 1'b0, "input direction");
        wr(`OLSUB_OFF_PIN_DIR, 32'h1);
        wr(`OLSUB_OFF_SOURCE, {24'h0, `OLSUB_SRC_OFF});
        settle();
        chk_pin(0, 1'b0, 1'b0, "source off");
        wr(`OLSUB_OFF_PIN_FLIP, 32'h0);
        $display("test drive control done");

        wr(`OLSUB_OFF_BIT_INDEX, 32'h3);
        wr(`OLSUB_OFF_BIT_LEVEL, 32'h1);
        rd(`OLSUB_OFF_WORD, 32'h08, "bit three set");
        wr(`OLSUB_OFF_WRITE_EN, 32'h0f);
        wr(`OLSUB_OFF_WORD, 32'hff);
        rd(`OLSUB_OFF_WORD, 32'h0f, "masked word");
        wr(`OLSUB_OFF_BIT_INDEX, 32'h5);
        wr(`OLSUB_OFF_BIT_LEVEL, 32'h1);
        rd(`OLSUB_OFF_WORD, 32'h2f, "bit path ignores enable");
        wr(`OLSUB_OFF_BIT_INDEX, 32'h0);
        wr(`OLSUB_OFF_BIT_LEVEL, 32'h0);
        rd(`OLSUB_OFF_WORD, 32'h2e, "bit zero cleared");
        wr(`OLSUB_OFF_BIT_INDEX, 32'h8);
        wr(`OLSUB_OFF_BIT_LEVEL, 32'h1);
        wr(8'h3f, 32'hffff_ffff);
        rd(`OLSUB_OFF_WORD, 32'h2e, "out of range index");
        rd(8'h3f, 32'h0, "unmapped address");
        wr(`OLSUB_OFF_WRITE_EN, 32'hd0);
        wr(`OLSUB_OFF_WORD, 32'hff);
        rd(`OLSUB_OFF_WORD, 32'hfe, "upper enable only");
        $display("test soft bits done");

        wr(`OLSUB_OFF_PIN_INDEX, 32'h1);
        wr(`OLSUB_OFF_PIN_DIR, 32'h1);
        wr(`OLSUB_OFF_SOURCE, 32'h45);
        wr(`OLSUB_OFF_PIN_INDEX, 32'h0);
        wr(`OLSUB_OFF_SOURCE, 32'h40);
        settle();
        chk_pin(1, 1'b1, 1'b1, "soft bit five");
        chk_pin(0, 1'b1, 1'b0, "soft bit zero");
        chk_pin(2, 1'b0, 1'b0, "untouched line");
        rd(`OLSUB_OFF_PIN_STATE, 32'h0000_000e, "released lines pulled up");
        $display("test soft sources done");
        complete_run();
    end
endmodule
